// ===== src/icsd_pkg.sv
/*
 package for the internal clock select and divide block: register offsets,
 field positions, reset values, write masks, source encodings, carriers.
 assumes a host register port with byte offsets and 32-bit data.
*/
package icsd_pkg;
    localparam logic [7:0] ICSD_OFS_MEM_CLK = 8'h04;
    localparam logic [7:0] ICSD_OFS_PIX_CLK = 8'h08;
    localparam logic [7:0] ICSD_OFS_PWR_SAVE = 8'h14;
    localparam logic [7:0] ICSD_OFS_PWM_CLK = 8'h70;
    localparam int ICSD_MEM_DIV_LSB = 4;
    localparam int ICSD_PIX_SRC_LSB = 0;
    localparam int ICSD_PIX_DIV_LSB = 4;
    localparam int ICSD_PWM_SRC_LSB = 1;
    localparam int ICSD_PWM_EN_BIT = 0;
    localparam int ICSD_PS_MODE_BIT = 0;
    localparam int ICSD_PS_STAT_BIT = 6;
    localparam logic [31:0] ICSD_RST_MEM_CLK = 32'h0000_0000;
    localparam logic [31:0] ICSD_RST_PIX_CLK = 32'h0000_0000;
    localparam logic [31:0] ICSD_RST_PWR_SAVE = 32'h0000_0001;
    localparam logic [31:0] ICSD_RST_PWM_CLK = 32'h0000_0000;
    localparam logic [31:0] ICSD_MASK_MEM_CLK = 32'h0000_0030;
    localparam logic [31:0] ICSD_MASK_PIX_CLK = 32'h0000_00ff;
    localparam logic [31:0] ICSD_MASK_PWR_SAVE = 32'h0000_0001;
    localparam logic [31:0] ICSD_MASK_PWM_CLK = 32'h0000_0007;
    localparam int ICSD_USB_FREQ_MHZ = 48;
    localparam int ICSD_MCLK_MAX_MHZ = 50;
    // clk_sys cycles without a usb input clock rising edge before usb is called stopped
    localparam int ICSD_USB_IDLE_CYCLES = 4;
    // source codes, pixel and pulse modulator
    localparam logic [3:0] ICSD_PIX_SRC_MEM = 4'h0;
    localparam logic [3:0] ICSD_PIX_SRC_BUS = 4'h1;
    localparam logic [3:0] ICSD_PIX_SRC_PRI = 4'h2;
    localparam logic [3:0] ICSD_PIX_SRC_SEC = 4'h3;
    localparam logic [1:0] ICSD_PWM_SRC_PRI = 2'h0;
    localparam logic [1:0] ICSD_PWM_SRC_SEC = 2'h1;
    localparam logic [1:0] ICSD_PWM_SRC_MEM = 2'h2;
    localparam logic [1:0] ICSD_PWM_SRC_PIX = 2'h3;

    typedef struct packed {
        logic bus;
        logic mem;
        logic pix;
        logic pwm;
        logic usb;
    } icsd_clk_en_type;

    typedef struct packed {
        logic sel;
        logic wr;
        logic [7:0] addr;
        logic [31:0] wdata;
    } icsd_reg_req_type;

    typedef struct packed {
        logic mem_access;
        logic lut_access;
        logic panel_on;
        logic usb_access;
    } icsd_activity_type;
endpackage

// ===== src/icsd_clock_ctrl.sv
/*
 clock select and divide control: turns the primary and secondary input clock edges into
 one-cycle enables for the bus, memory, pixel and pulse modulator domains,
 and holds the clock configuration registers.
 assumes the primary, secondary and usb clocks arrive as sampled levels
 slower than half of clk_sys; the host port is synchronous to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module icsd_clock_ctrl #(
    parameter int USB_IDLE_CYCLES = icsd_pkg::ICSD_USB_IDLE_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic primary_input_clock,
    input wire logic secondary_input_clock,
    input wire logic usb_input_clock,
    input wire logic bus_clock_divide_strap,
    input wire icsd_pkg::icsd_reg_req_type reg_req,
    input wire icsd_pkg::icsd_activity_type activity,
    input wire logic mem_ctrl_idle,
    output logic [31:0] reg_rdata,
    output logic reg_ack,
    output logic reg_err,
    output icsd_pkg::icsd_clk_en_type clk_en,
    output logic usb_clock_active
);
    typedef enum logic [1:0] {
        ICSD_ST_RUN,
        ICSD_ST_DRAIN,
        ICSD_ST_SAVE
    } icsd_ps_state_type;

    // two-flop synchronisers for the external clock levels and the strap
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] prev;
    logic [3:0] rise;
    always_ff @(posedge clk_sys) begin
        sync1 <= {bus_clock_divide_strap, usb_input_clock,
                  secondary_input_clock, primary_input_clock};
        sync2 <= sync1;
        prev <= sync2;
    end
    assign rise = sync2 & ~prev;

    logic strap_q;
    logic next_strap_q;
    logic bus_half;
    logic next_bus_half;
    logic [1:0] mem_cnt;
    logic [1:0] next_mem_cnt;
    logic [2:0] pix_cnt;
    logic [2:0] next_pix_cnt;
    logic [31:0] mem_cfg;
    logic [31:0] next_mem_cfg;
    logic [31:0] pix_cfg;
    logic [31:0] next_pix_cfg;
    logic [31:0] pwm_cfg;
    logic [31:0] next_pwm_cfg;
    logic ps_mode;
    logic next_ps_mode;
    icsd_ps_state_type ps_state;
    icsd_ps_state_type next_ps_state;
    logic [1:0] mem_div_act;
    logic [1:0] next_mem_div_act;
    logic [7:0] pix_act;
    logic [7:0] next_pix_act;
    logic [1:0] pwm_act;
    logic [1:0] next_pwm_act;
    logic [7:0] usb_idle;
    logic [7:0] next_usb_idle;
    logic [31:0] next_reg_rdata;
    logic next_reg_ack;
    logic next_reg_err;
    icsd_pkg::icsd_clk_en_type next_clk_en;
    logic next_usb_clock_active;

    // pixel divisor code to terminal count; unknown codes divide by one
    function automatic logic [2:0] icsd_pix_last(input logic [3:0] code);
        logic [2:0] r;
        r = 3'h0;
        if (code == 4'h1) begin
            r = 3'h1;
        end else if (code == 4'h2) begin
            r = 3'h2;
        end else if (code == 4'h3) begin
            r = 3'h3;
        end else if (code == 4'h4) begin
            r = 3'h7;
        end
        return r;
    endfunction

    // register offset to a small index, 0 for an unmapped offset; read and
    // write share it so the two decodes cannot drift apart
    function automatic logic [2:0] icsd_reg_index(input logic [7:0] addr);
        logic [2:0] r;
        r = 3'h0;
        if (addr == icsd_pkg::ICSD_OFS_MEM_CLK) begin
            r = 3'h1;
        end else if (addr == icsd_pkg::ICSD_OFS_PIX_CLK) begin
            r = 3'h2;
        end else if (addr == icsd_pkg::ICSD_OFS_PWR_SAVE) begin
            r = 3'h3;
        end else if (addr == icsd_pkg::ICSD_OFS_PWM_CLK) begin
            r = 3'h4;
        end
        return r;
    endfunction

    logic [2:0] reg_idx;
    logic bus_tick;
    logic mem_tick;
    logic pix_src_tick;
    logic pix_tick;
    logic pwm_src_tick;
    logic mem_need;
    logic pix_need;
    logic reg_hit;
    always_comb begin
        next_strap_q = strap_q;
        next_bus_half = bus_half;
        next_mem_cnt = mem_cnt;
        next_pix_cnt = pix_cnt;
        next_mem_cfg = mem_cfg;
        next_pix_cfg = pix_cfg;
        next_pwm_cfg = pwm_cfg;
        next_ps_mode = ps_mode;
        next_ps_state = ps_state;
        next_mem_div_act = mem_div_act;
        next_pix_act = pix_act;
        next_pwm_act = pwm_act;
        next_usb_idle = usb_idle;
        next_reg_rdata = 32'h0000_0000;
        next_reg_ack = 1'b0;
        next_reg_err = 1'b0;
        reg_hit = 1'b0;
        reg_idx = icsd_reg_index(reg_req.addr);
        // strap is taken while reset holds it steady
        if (rst) begin
            next_strap_q = sync2[3];
        end
        // bus clock is every primary edge or every second one
        bus_tick = rise[0] & (~strap_q | bus_half);
        if (rise[0]) begin
            next_bus_half = ~bus_half;
        end
        // memory divider counts bus ticks, 1 to 4
        mem_tick = bus_tick & (mem_cnt == mem_div_act);
        if (bus_tick) begin
            next_mem_cnt = mem_tick ? 2'h0 : 2'(mem_cnt + 2'h1);
        end
        // pixel source then divisor
        if (pix_act[3:0] == icsd_pkg::ICSD_PIX_SRC_BUS) begin
            pix_src_tick = bus_tick;
        end else if (pix_act[3:0] == icsd_pkg::ICSD_PIX_SRC_PRI) begin
            pix_src_tick = rise[0];
        end else if (pix_act[3:0] == icsd_pkg::ICSD_PIX_SRC_SEC) begin
            pix_src_tick = rise[1];
        end else begin
            pix_src_tick = mem_tick;
        end
        pix_tick = pix_src_tick & (pix_cnt == icsd_pix_last(pix_act[7:4]));
        if (pix_src_tick) begin
            next_pix_cnt = pix_tick ? 3'h0 : 3'(pix_cnt + 3'h1);
        end
        // pulse modulator source
        if (pwm_act == icsd_pkg::ICSD_PWM_SRC_SEC) begin
            pwm_src_tick = rise[1];
        end else if (pwm_act == icsd_pkg::ICSD_PWM_SRC_MEM) begin
            pwm_src_tick = mem_tick;
        end else if (pwm_act == icsd_pkg::ICSD_PWM_SRC_PIX) begin
            pwm_src_tick = pix_tick;
        end else begin
            pwm_src_tick = rise[0];
        end
        // need of each gated domain, independent of its frequency
        mem_need = activity.mem_access | activity.lut_access
                   | activity.panel_on;
        pix_need = activity.panel_on & ~ps_mode;
        // new settings load only on a completed output period, so no
        // shortened or stretched pulse reaches a domain
        // a gated pixel or pulse modulator domain sees no pulses, so it may take a new setting at once
        if (mem_tick) begin
            next_mem_div_act = mem_cfg[icsd_pkg::ICSD_MEM_DIV_LSB +: 2];
        end
        if (pix_tick | ~pix_need) begin
            next_pix_act = pix_cfg[7:0];
        end
        if (pwm_src_tick | ~pwm_cfg[icsd_pkg::ICSD_PWM_EN_BIT]) begin
            next_pwm_act = pwm_cfg[icsd_pkg::ICSD_PWM_SRC_LSB +: 2];
        end
        // usb clock seen toggling recently
        if (rise[2]) begin
            next_usb_idle = 8'h00;
        end else if (usb_idle != 8'(USB_IDLE_CYCLES)) begin
            next_usb_idle = 8'(usb_idle + 8'h01);
        end
        // memory controller power save handshake
        case (ps_state)
            ICSD_ST_RUN: begin
                if (ps_mode) begin
                    next_ps_state = ICSD_ST_DRAIN;
                end
            end
            ICSD_ST_DRAIN: begin
                if (!ps_mode) begin
                    next_ps_state = ICSD_ST_RUN;
                end else if (mem_ctrl_idle) begin
                    next_ps_state = ICSD_ST_SAVE;
                end
            end
            default: begin
                if (!ps_mode) begin
                    next_ps_state = ICSD_ST_RUN;
                end
            end
        endcase
        // register port; the block's registers need only clk_sys, not the bus clock enable
        if (reg_req.sel) begin
            next_reg_ack = 1'b1;
            if (reg_idx == 3'h1) begin
                reg_hit = 1'b1;
                next_reg_rdata = mem_cfg;
            end else if (reg_idx == 3'h2) begin
                reg_hit = 1'b1;
                next_reg_rdata = pix_cfg;
            end else if (reg_idx == 3'h3) begin
                reg_hit = 1'b1;
                next_reg_rdata = 32'({ps_state == ICSD_ST_SAVE,
                                      5'h00, ps_mode});
            end else if (reg_idx == 3'h4) begin
                reg_hit = 1'b1;
                next_reg_rdata = pwm_cfg;
            end
            next_reg_err = ~reg_hit;
            if (reg_req.wr) begin
                if (reg_idx == 3'h1) begin
                    next_mem_cfg = reg_req.wdata & icsd_pkg::ICSD_MASK_MEM_CLK;
                end else if (reg_idx == 3'h2) begin
                    next_pix_cfg = reg_req.wdata & icsd_pkg::ICSD_MASK_PIX_CLK;
                end else if (reg_idx == 3'h3) begin
                    next_ps_mode = reg_req.wdata[icsd_pkg::ICSD_PS_MODE_BIT];
                end else if (reg_idx == 3'h4) begin
                    next_pwm_cfg = reg_req.wdata & icsd_pkg::ICSD_MASK_PWM_CLK;
                end
            end
        end
        // gating by need, independent of programmed frequency
        next_clk_en.bus = bus_tick;
        next_clk_en.mem = mem_tick & mem_need & (ps_state != ICSD_ST_SAVE);
        next_clk_en.pix = pix_tick & pix_need;
        // only the pulse modulator enable looks at an enable bit of its own
        next_clk_en.pwm = pwm_src_tick & pwm_cfg[icsd_pkg::ICSD_PWM_EN_BIT];
        next_usb_clock_active = usb_idle != 8'(USB_IDLE_CYCLES);
        next_clk_en.usb = rise[2] & activity.usb_access;
        // dividers restart from phase zero on reset
        if (rst) begin
            next_bus_half = 1'b0;
            next_mem_cnt = 2'h0;
            next_pix_cnt = 3'h0;
            next_mem_cfg = icsd_pkg::ICSD_RST_MEM_CLK;
            next_pix_cfg = icsd_pkg::ICSD_RST_PIX_CLK;
            next_pwm_cfg = icsd_pkg::ICSD_RST_PWM_CLK;
            next_ps_mode = icsd_pkg::ICSD_RST_PWR_SAVE[0];
            next_ps_state = ICSD_ST_RUN;
            next_mem_div_act = 2'h0;
            next_pix_act = 8'h00;
            next_pwm_act = 2'h0;
            next_usb_idle = 8'(USB_IDLE_CYCLES);
            next_reg_rdata = 32'h0000_0000;
            next_reg_ack = 1'b0;
            next_reg_err = 1'b0;
            next_clk_en = '0;
            next_usb_clock_active = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        strap_q <= next_strap_q;
        bus_half <= next_bus_half;
        mem_cnt <= next_mem_cnt;
        pix_cnt <= next_pix_cnt;
        mem_cfg <= next_mem_cfg;
        pix_cfg <= next_pix_cfg;
        pwm_cfg <= next_pwm_cfg;
        ps_mode <= next_ps_mode;
        ps_state <= next_ps_state;
        mem_div_act <= next_mem_div_act;
        pix_act <= next_pix_act;
        pwm_act <= next_pwm_act;
        usb_idle <= next_usb_idle;
        reg_rdata <= next_reg_rdata;
        reg_ack <= next_reg_ack;
        reg_err <= next_reg_err;
        clk_en <= next_clk_en;
        usb_clock_active <= next_usb_clock_active;
    end
endmodule
`default_nettype wire

// ===== verification/icsd_clock_ctrl_sva.sv
/*
 checker for the clock select and divide control, port relations only.
 assumes it is bound to every icsd_clock_ctrl instance.
*/
`timescale 1ns/1ps
`default_nettype none
module icsd_clock_ctrl_sva #(
    parameter int USB_IDLE_CYCLES = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic usb_input_clock,
    input wire icsd_pkg::icsd_reg_req_type reg_req,
    input wire icsd_pkg::icsd_activity_type activity,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic reg_err,
    input wire icsd_pkg::icsd_clk_en_type clk_en,
    input wire logic usb_clock_active
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [3:0] idle;
    logic mapped;
    assign mapped = reg_req.addr inside {8'h04, 8'h08, 8'h14, 8'h70};
    // saturates so a long stop never wraps back to a small count
    always_ff @(posedge clk_sys) begin
        if (rst || !$stable(usb_input_clock)) begin
            idle <= 4'h0;
        end else begin
            idle <= idle + {3'h0, idle != 4'hf};
        end
    end
    a_ack_answer: assert property (reg_req.sel |=> reg_ack)
        else $error("no ack one cycle after select");
    a_ack_only: assert property (!reg_req.sel |=> !reg_ack && !reg_err)
        else $error("ack without select");
    a_err_unmapped: assert property (reg_req.sel && !mapped |=>
        reg_err && reg_rdata == 32'h0) else $error("unmapped not refused");
    a_err_mapped: assert property (reg_req.sel && mapped |=> !reg_err)
        else $error("mapped address refused");
    a_rdata_idle: assert property (!reg_ack |-> reg_rdata == 32'h0)
        else $error("read data outside ack");
    a_bus_single: assert property (clk_en.bus |=> !clk_en.bus)
        else $error("bus enable longer than one cycle");
    a_mem_gated: assert property ((!(activity.mem_access ||
        activity.lut_access || activity.panel_on))[*3] |-> !clk_en.mem)
        else $error("memory enable while idle");
    a_pix_gated: assert property ((!activity.panel_on)[*3] |-> !clk_en.pix)
        else $error("pixel enable without panel");
    a_usb_gated: assert property ((!activity.usb_access)[*3] |-> !clk_en.usb)
        else $error("usb enable without usb access");
    a_mem_from_bus: assert property (clk_en.mem |->
        clk_en.bus || $past(clk_en.bus)) else $error("memory tick off bus tick");
    a_usb_stops: assert property (idle > USB_IDLE_CYCLES + 5
        |-> !usb_clock_active) else $error("usb active with stopped clock");
    cover property (clk_en.mem);
    cover property (clk_en.pix);
    cover property (clk_en.pwm);
    cover property (reg_err);
endmodule
bind icsd_clock_ctrl icsd_clock_ctrl_sva #(
    .USB_IDLE_CYCLES(USB_IDLE_CYCLES)
) u_sva (
    .clk_sys(clk_sys), .rst(rst), .usb_input_clock(usb_input_clock),
    .reg_req(reg_req), .activity(activity), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .reg_err(reg_err), .clk_en(clk_en),
    .usb_clock_active(usb_clock_active)
);
`default_nettype wire

// ===== verification/icsd_clock_src.sv
/*
 model of the external clock sources: primary, secondary and usb clocks.
 assumes clk_sys rising edges at 25 ns plus 50 ns steps; no edge here meets them.
*/
`timescale 1ns/1ps
`default_nettype none
module icsd_clock_src (
    input wire logic usb_run,
    output logic primary_input_clock,
    output logic secondary_input_clock,
    output logic usb_input_clock
);
    initial begin
        primary_input_clock = 1'b0;
        secondary_input_clock = 1'b0;
        usb_input_clock = 1'b0;
    end
    // scaled rates: primary 8, secondary 12, usb 4 clk_sys cycles
    always #200 primary_input_clock = !primary_input_clock;
    always #300 secondary_input_clock = !secondary_input_clock;
    // usb clock stands still while stopped
    always #100 if (usb_run) usb_input_clock = !usb_input_clock;
endmodule
`default_nettype wire

// ===== verification/test_internal_clock_select_divide.sv
/*
 bench for the clock select and divide control: registers, rates, gating.
 assumes the source model makes the input clocks; bench drives the rest.
*/
`timescale 1ns/1ps
`default_nettype none
module test_internal_clock_select_divide;
    typedef struct {
        logic [7:0] a;
        logic [31:0] wd;
        logic [31:0] rd;
        logic err;
    } icsd_row_type;
    logic clk_sys, rst, strap, usb_run, idle, ack, err, uact, pri, sec, usbc;
    logic er;
    logic [31:0] rdata, rd;
    icsd_pkg::icsd_reg_req_type req;
    icsd_pkg::icsd_activity_type act;
    icsd_pkg::icsd_clk_en_type en;
    int error_cnt = 0;
    int total_checks = 0;
    int n[7];
    int sc[4];
    int dv[5] = '{1, 2, 3, 4, 8};
    icsd_row_type rows[6] = '{
        '{8'h04, 32'hffffffff, 32'h30, 1'b0},
        '{8'h08, 32'hffffffff, 32'hff, 1'b0},
        '{8'h70, 32'hffffffff, 32'h07, 1'b0},
        '{8'h14, 32'h0, 32'h0, 1'b0},
        '{8'h0c, 32'hffffffff, 32'h0, 1'b1},
        '{8'h00, 32'h1, 32'h0, 1'b1}};
    icsd_clock_ctrl #(.USB_IDLE_CYCLES(6)) DUT (
        .clk_sys(clk_sys), .rst(rst), .primary_input_clock(pri),
        .secondary_input_clock(sec), .usb_input_clock(usbc),
        .bus_clock_divide_strap(strap), .reg_req(req), .activity(act),
        .mem_ctrl_idle(idle), .reg_rdata(rdata), .reg_ack(ack),
        .reg_err(err), .clk_en(en), .usb_clock_active(uact));
    icsd_clock_src src (.usb_run(usb_run), .primary_input_clock(pri),
        .secondary_input_clock(sec), .usb_input_clock(usbc));
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = !clk_sys;
    end
    task results;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", s, e, g);
        end
    endtask
    // edge counts carry one tick of phase slack at each end of a window
    task near(input string s, input int e, input int g);
        chk(s, e, (g >= e - 1 && g <= e + 1) ? e : g);
    endtask
    task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        req <= '{1'b1, w, a, d};
        @(posedge clk_sys);
        req.sel <= 1'b0;
        #1;
        chk("reg_ack", 1'b1, ack);
        rd = rdata;
        er = err;
    endtask
    // lets a new setting settle, then counts enables and input clock edges
    task win(input int c);
        logic p0, s0;
        repeat (100) @(posedge clk_sys);
        n = '{default: 0};
        p0 = pri;
        s0 = sec;
        repeat (c) begin
            @(posedge clk_sys);
            #1;
            n[0] += en.bus;
            n[1] += en.mem;
            n[2] += en.pix;
            n[3] += en.pwm;
            n[4] += en.usb;
            n[5] += pri && !p0;
            n[6] += sec && !s0;
            p0 = pri;
            s0 = sec;
        end
    endtask
    initial begin
        rst = 1'b1;
        strap = 1'b0;
        usb_run = 1'b0;
        idle = 1'b0;
        req = '0;
        act = '0;
        repeat (8) @(posedge clk_sys);
        #1;
        chk("clk_en in reset", 32'h0, 32'(en));
        @(posedge clk_sys);
        rst <= 1'b0;
        acc(0, 8'h14, 0);
        chk("power_save_config reset", 32'h1, rd);
        foreach (rows[i]) begin
            acc(1, rows[i].a, rows[i].wd);
            acc(0, rows[i].a, 0);
            chk("rdata", rows[i].rd, rd);
            chk("reg_err", rows[i].err, er);
        end
        @(posedge clk_sys);
        act <= 4'b1010;
        win(400);
        near("bus ticks strap low", 50, n[0]);
        for (int d = 0; d < 4; d++) begin
            acc(1, 8'h04, d * 16);
            win(240);
            near("mem ticks", n[0] / (d + 1), n[1]);
        end
        acc(1, 8'h04, 0);
        for (int s = 0; s < 4; s++) begin
            for (int v = 0; v < 5; v++) begin
                acc(1, 8'h08, s + v * 16);
                win(480);
                sc = '{n[1], n[0], n[5], n[6]};
                near("pix ticks", sc[s] / dv[v], n[2]);
            end
        end
        acc(1, 8'h08, 32'h11);
        for (int p = 0; p < 4; p++) begin
            acc(1, 8'h70, p * 2 + 1);
            win(480);
            sc = '{n[5], n[6], n[1], n[2]};
            near("pwm ticks", sc[p], n[3]);
        end
        acc(1, 8'h70, 0);
        win(200);
        chk("pwm ticks off", 0, n[3]);
        @(posedge clk_sys);
        act <= 4'b0001;
        usb_run <= 1'b1;
        win(200);
        near("usb ticks", 50, n[4]);
        chk("usb active", 1'b1, uact);
        chk("mem ticks usb only", 0, n[1] + n[2]);
        @(posedge clk_sys);
        usb_run <= 1'b0;
        win(100);
        chk("usb stopped", 1'b0, uact);
        @(posedge clk_sys);
        act <= 4'b1010;
        idle <= 1'b1;
        acc(1, 8'h14, 1);
        win(200);
        chk("ticks in save", 0, n[1] + n[2]);
        acc(0, 8'h14, 0);
        chk("save status", 32'h41, rd);
        @(posedge clk_sys);
        rst <= 1'b1;
        strap <= 1'b1; // held through reset
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        win(400);
        near("bus ticks strap high", 25, n[0]);
        acc(0, 8'h08, 0);
        chk("pixel_clock_config reset", 32'h0, rd);
        results();
    end
    initial begin
        #2000000;
        error_cnt++;
        results();
    end
endmodule
`default_nettype wire
